// file: hdl/internal_memory_host_port.sv
// Host port read modes, write buffering and pin function selection
`timescale 1ns/1ns
module internal_memory_host_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic host_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_addr_latch,
  input wire logic [15:0] host_addr_data_in,
  output logic [15:0] host_addr_data_out,
  output logic host_addr_data_oe,
  output logic host_acknowledge_n,
  output logic mem_req,
  output logic mem_we,
  output logic mem_is_pm,
  output logic [13:0] mem_addr,
  output logic [23:0] mem_wdata,
  input wire logic [23:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic core_ovl_we,
  input wire logic [15:0] core_ovl_wdata,
  output logic [15:0] host_port_overlay_ctrl,
  input wire logic core_sysctl_we,
  input wire logic [15:0] core_sysctl_wdata,
  output logic [15:0] sys_ctrl,
  input wire logic strap_pin_a,
  input wire logic strap_pin_b,
  input wire logic strap_pin_c,
  input wire logic strap_pin_d,
  output logic [3:0] strap_bits,
  output logic ext_pins_host_fn,
  output logic plus_pins_dual_fn,
  output logic serial_tx_or_flag_out,
  input wire logic tx_sync_or_irq_b_in,
  output logic tx_sync_or_irq_b_out,
  output logic tx_sync_or_irq_b_oe,
  input wire logic rx_sync_or_irq_a_in,
  output logic rx_sync_or_irq_a_out,
  output logic rx_sync_or_irq_a_oe,
  input wire logic serial_rx_or_flag_in,
  input wire logic sport_tx_bit,
  input wire logic sport_tfs_out,
  input wire logic sport_tfs_drive,
  input wire logic sport_rfs_out,
  input wire logic sport_rfs_drive,
  input wire logic flag_out_bit,
  output logic sport_rx_bit,
  output logic sport_tfs_in,
  output logic sport_rfs_in,
  output logic irq_a_n,
  output logic irq_b_n,
  output logic flag_in_bit
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = $bits(host_port_pkg::pin_in_type);

  host_port_pkg::pin_in_type pin_raw, filt;
  logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

  always_comb begin
    pin_raw.sel_n = host_select_n;
    pin_raw.rd_n = host_read_strobe_n;
    pin_raw.wr_n = host_write_strobe_n;
    pin_raw.latch = host_addr_latch;
    pin_raw.bus = host_addr_data_in;
    pin_raw.tx_sync = tx_sync_or_irq_b_in;
    pin_raw.rx_sync = rx_sync_or_irq_a_in;
    pin_raw.rx_data = serial_rx_or_flag_in;
    pin_raw.strap = {strap_pin_d, strap_pin_c, strap_pin_b, strap_pin_a};
    // A bit moves only when the last two stages agree
    filt_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
  end

  // Idle pin levels after reset keep the strobes inactive
  localparam logic [PIN_W-1:0] PIN_IDLE = {3'h7, {PIN_W-3{1'b0}}};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= PIN_IDLE;
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
      filt_reg <= PIN_IDLE;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  assign filt = filt_reg;

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  host_port_pkg::fifo_entry_type push_entry, pop_entry;
  logic push_valid, push_ready, pop_valid, pop_ready;

  sync_fifo #(
    .WIDTH($bits(host_port_pkg::fifo_entry_type)),
    .DEPTH(host_port_pkg::FIFO_DEPTH)
  ) write_buffer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_data(push_entry),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(pop_entry),
    .out_valid(pop_valid),
    .out_ready(pop_ready)
  );

  // ----------------------------------------------------------------
  // Host cycles and memory access
  // ----------------------------------------------------------------
  host_port_pkg::host_state_type host_state_reg, host_state_next;
  host_port_pkg::mem_state_type mem_state_reg, mem_state_next;
  logic [13:0] addr_reg, addr_next, fetch_addr_reg, fetch_addr_next;
  logic is_pm_reg, is_pm_next, half_reg, half_next, fetch_pm_reg, fetch_pm_next;
  logic fetch_pending_reg, fetch_pending_next;
  logic [15:0] fetched_reg, fetched_next, pm_hi_reg, pm_hi_next;
  logic [7:0] pm_low_reg, pm_low_next;
  logic [15:0] ovl_reg, ovl_next, bus_out_reg, bus_out_next;
  logic bus_oe_reg, bus_oe_next, ack_n_reg, ack_n_next;
  logic mem_req_reg, mem_req_next, mem_we_reg, mem_we_next, mem_pm_reg, mem_pm_next;
  logic [13:0] mem_addr_reg, mem_addr_next;
  logic [23:0] mem_wdata_reg, mem_wdata_next;
  logic rd_active, wr_active, sro_mode, access_done;

  assign rd_active = ~filt.sel_n & ~filt.rd_n;
  assign wr_active = ~filt.sel_n & ~filt.wr_n;
  assign sro_mode = ovl_reg[host_port_pkg::SRO_BIT];
  assign pop_ready = (mem_state_reg == host_port_pkg::MEM_IDLE);
  // Second program half or any data word closes the word
  assign access_done = ~is_pm_reg | half_reg;

  always_comb begin
    host_state_next = host_state_reg;
    mem_state_next = mem_state_reg;
    addr_next = addr_reg;
    is_pm_next = is_pm_reg;
    half_next = half_reg;
    fetch_addr_next = fetch_addr_reg;
    fetch_pm_next = fetch_pm_reg;
    fetch_pending_next = fetch_pending_reg;
    fetched_next = fetched_reg;
    pm_hi_next = pm_hi_reg;
    pm_low_next = pm_low_reg;
    ovl_next = ovl_reg;
    bus_out_next = bus_out_reg;
    bus_oe_next = bus_oe_reg;
    mem_req_next = mem_req_reg;
    mem_we_next = mem_we_reg;
    mem_pm_next = mem_pm_reg;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    push_valid = 1'b0;
    push_entry = '0;
    case (host_state_reg)
      host_port_pkg::HOST_IDLE: begin
        if (~filt.sel_n && filt.latch) begin
          addr_next = filt.bus[host_port_pkg::ADDR_W-1:0];
          is_pm_next = ~filt.bus[host_port_pkg::ADDR_DM_BIT];
          half_next = 1'b0;
        end else if (rd_active) begin
          host_state_next = host_port_pkg::HOST_READ;
          bus_oe_next = 1'b1;
          bus_out_next = fetched_reg;
          if (is_pm_reg && half_reg) begin
            fetched_next = {host_port_pkg::PM_PAD, pm_low_reg};
          end else begin
            fetch_pending_next = 1'b1;
            fetch_addr_next = addr_reg;
            fetch_pm_next = is_pm_reg;
          end
        end else if (wr_active) begin
          host_state_next = host_port_pkg::HOST_WRITE;
        end
      end
      host_port_pkg::HOST_READ: begin
        // Short Read Only keeps the word caught at the start
        if (!fetch_pending_reg && !sro_mode) begin
          bus_out_next = fetched_reg;
        end
        if (!rd_active) begin
          host_state_next = host_port_pkg::HOST_IDLE;
          bus_oe_next = 1'b0;
          half_next = is_pm_reg & ~half_reg;
          if (access_done) begin
            addr_next = addr_reg + host_port_pkg::ADDR_STEP;
          end
        end
      end
      host_port_pkg::HOST_WRITE: begin
        if (!wr_active) begin
          host_state_next = host_port_pkg::HOST_IDLE;
          half_next = is_pm_reg & ~half_reg;
          if (!access_done) begin
            pm_hi_next = filt.bus;
          end else begin
            push_valid = 1'b1;
            push_entry.is_pm = is_pm_reg;
            push_entry.addr = addr_reg;
            push_entry.data = is_pm_reg ?
                {pm_hi_reg, filt.bus[host_port_pkg::PM_LOW_W-1:0]} :
                {host_port_pkg::PM_PAD, filt.bus};
            addr_next = addr_reg + host_port_pkg::ADDR_STEP;
          end
        end
      end
      default: host_state_next = host_port_pkg::HOST_IDLE;
    endcase
    if (core_ovl_we) begin
      ovl_next = core_ovl_wdata;
    end
    case (mem_state_reg)
      host_port_pkg::MEM_IDLE: begin
        // Buffered writes drain before a fetch to keep order
        if (pop_valid) begin
          if (!pop_entry.is_pm && pop_entry.addr == host_port_pkg::OVL_ADDR) begin
            ovl_next = pop_entry.data[host_port_pkg::DATA_W-1:0];
          end else begin
            mem_state_next = host_port_pkg::MEM_WRITE;
            mem_req_next = 1'b1;
            mem_we_next = 1'b1;
            mem_pm_next = pop_entry.is_pm;
            mem_addr_next = pop_entry.addr;
            mem_wdata_next = pop_entry.data;
          end
        end else if (fetch_pending_reg) begin
          if (!fetch_pm_reg && fetch_addr_reg == host_port_pkg::OVL_ADDR) begin
            fetched_next = ovl_reg;
            fetch_pending_next = 1'b0;
          end else begin
            mem_state_next = host_port_pkg::MEM_READ;
            mem_req_next = 1'b1;
            mem_we_next = 1'b0;
            mem_pm_next = fetch_pm_reg;
            mem_addr_next = fetch_addr_reg;
          end
        end
      end
      host_port_pkg::MEM_WRITE: begin
        if (mem_ack) begin
          mem_state_next = host_port_pkg::MEM_IDLE;
          mem_req_next = 1'b0;
          mem_we_next = 1'b0;
        end
      end
      host_port_pkg::MEM_READ: begin
        if (mem_ack) begin
          mem_state_next = host_port_pkg::MEM_IDLE;
          mem_req_next = 1'b0;
          fetch_pending_next = 1'b0;
          pm_low_next = mem_rdata[host_port_pkg::PM_LOW_W-1:0];
          fetched_next = fetch_pm_reg ?
              mem_rdata[host_port_pkg::PM_W-1:host_port_pkg::PM_LOW_W] :
              mem_rdata[host_port_pkg::DATA_W-1:0];
        end
      end
      default: mem_state_next = host_port_pkg::MEM_IDLE;
    endcase
    // Busy while a cycle runs, a fetch is open or the buffer is full
    ack_n_next = ~((host_state_next == host_port_pkg::HOST_IDLE) &&
                   !fetch_pending_next && push_ready && !push_valid);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_state_reg <= host_port_pkg::HOST_IDLE;
      mem_state_reg <= host_port_pkg::MEM_IDLE;
      addr_reg <= '0;
      is_pm_reg <= 1'b0;
      half_reg <= 1'b0;
      fetch_addr_reg <= '0;
      fetch_pm_reg <= 1'b0;
      fetch_pending_reg <= 1'b0;
      fetched_reg <= '0;
      pm_hi_reg <= '0;
      pm_low_reg <= '0;
      ovl_reg <= host_port_pkg::OVL_RESET;
      bus_out_reg <= '0;
      bus_oe_reg <= 1'b0;
      ack_n_reg <= 1'b1;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_pm_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_wdata_reg <= '0;
    end else begin
      host_state_reg <= host_state_next;
      mem_state_reg <= mem_state_next;
      addr_reg <= addr_next;
      is_pm_reg <= is_pm_next;
      half_reg <= half_next;
      fetch_addr_reg <= fetch_addr_next;
      fetch_pm_reg <= fetch_pm_next;
      fetch_pending_reg <= fetch_pending_next;
      fetched_reg <= fetched_next;
      pm_hi_reg <= pm_hi_next;
      pm_low_reg <= pm_low_next;
      ovl_reg <= ovl_next;
      bus_out_reg <= bus_out_next;
      bus_oe_reg <= bus_oe_next;
      ack_n_reg <= ack_n_next;
      mem_req_reg <= mem_req_next;
      mem_we_reg <= mem_we_next;
      mem_pm_reg <= mem_pm_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
    end
  end

  assign host_addr_data_out = bus_out_reg;
  assign host_addr_data_oe = bus_oe_reg;
  assign host_acknowledge_n = ack_n_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_is_pm = mem_pm_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign host_port_overlay_ctrl = ovl_reg;

  // ----------------------------------------------------------------
  // Mode straps
  // ----------------------------------------------------------------
  logic [2:0] strap_cnt_reg, strap_cnt_next;
  logic [3:0] strap_reg, strap_next;
  logic host_fn_reg, host_fn_next;

  // Samples every cycle until the count reaches STRAP_SETTLE, then holds the last sample
  always_comb begin
    strap_cnt_next = strap_cnt_reg;
    strap_next = strap_reg;
    host_fn_next = host_fn_reg;
    if (strap_cnt_reg != host_port_pkg::STRAP_SETTLE) begin
      strap_cnt_next = strap_cnt_reg + host_port_pkg::STRAP_STEP;
      strap_next = filt.strap;
      host_fn_next = filt.strap[2];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_reg <= '0;
      strap_reg <= '0;
      host_fn_reg <= 1'b0;
    end else begin
      strap_cnt_reg <= strap_cnt_next;
      strap_reg <= strap_next;
      host_fn_reg <= host_fn_next;
    end
  end

  assign strap_bits = strap_reg;
  assign ext_pins_host_fn = host_fn_reg;

  // ----------------------------------------------------------------
  // Second serial port pin sharing
  // ----------------------------------------------------------------
  logic [15:0] sysctl_reg, sysctl_next;
  logic [11:0] pins_reg, pins_next;
  logic cfg;

  assign cfg = sysctl_reg[host_port_pkg::SPORT_CFG_BIT];

  always_comb begin
    sysctl_next = core_sysctl_we ? core_sysctl_wdata : sysctl_reg;
    // Unselected inputs rest idle so neither side sees stray edges
    pins_next[0] = cfg ? sport_tx_bit : flag_out_bit;
    pins_next[1] = sport_tfs_out;
    pins_next[2] = cfg & sport_tfs_drive;
    pins_next[3] = sport_rfs_out;
    pins_next[4] = cfg & sport_rfs_drive;
    pins_next[5] = cfg & filt.rx_data;
    pins_next[6] = cfg & filt.tx_sync;
    pins_next[7] = cfg & filt.rx_sync;
    pins_next[8] = cfg | filt.rx_sync;
    pins_next[9] = cfg | filt.tx_sync;
    pins_next[10] = ~cfg & filt.rx_data;
    pins_next[11] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysctl_reg <= host_port_pkg::SYSCTL_RESET;
      pins_reg <= 12'h000;
    end else begin
      sysctl_reg <= sysctl_next;
      pins_reg <= pins_next;
    end
  end

  assign sys_ctrl = sysctl_reg;
  assign serial_tx_or_flag_out = pins_reg[0];
  assign tx_sync_or_irq_b_out = pins_reg[1];
  assign tx_sync_or_irq_b_oe = pins_reg[2];
  assign rx_sync_or_irq_a_out = pins_reg[3];
  assign rx_sync_or_irq_a_oe = pins_reg[4];
  assign sport_rx_bit = pins_reg[5];
  assign sport_tfs_in = pins_reg[6];
  assign sport_rfs_in = pins_reg[7];
  assign irq_a_n = pins_reg[8];
  assign irq_b_n = pins_reg[9];
  assign flag_in_bit = pins_reg[10];
  assign plus_pins_dual_fn = pins_reg[11];

endmodule : internal_memory_host_port

// file: shared/host_port_pkg.sv
// Constants and types shared by the internal memory host port design
// ----------------------------------------------------------------
// What this block does
// - Overlay bit 14 enables Short Read Only; resets zero
// - Core or host may write that enable bit
// - Short Read Only drives previously fetched word
// - Acknowledge goes high once host read starts
// - Program word in two halves, data word one
// - Strap C one gives shared pins host functions
// - Straps captured at reset release, then held
// - Plus-sign pins keep both functions in any mode
// - Control bit 10 one selects serial port pins
// - Bit 10 zero selects interrupts and flags
// - Serial port configure bit resets to one
// ----------------------------------------------------------------
package host_port_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 14;
  localparam int PM_W = 24;
  localparam int PM_LOW_W = 8;
  localparam int STRAP_W = 4;
  localparam int FIFO_DEPTH = 16;

  localparam logic [ADDR_W-1:0] OVL_ADDR = 14'h3fe7;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 14'h0001;
  localparam int SRO_BIT = 14;
  localparam int ADDR_DM_BIT = 14;
  localparam int SPORT_CFG_BIT = 10;
  localparam logic [DATA_W-1:0] OVL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] SYSCTL_RESET = 16'h0400;
  localparam logic [PM_LOW_W-1:0] PM_PAD = 8'h00;
  localparam logic [2:0] STRAP_SETTLE = 3'h5;
  localparam logic [2:0] STRAP_STEP = 3'h1;

  typedef struct packed {
    logic is_pm;
    logic [ADDR_W-1:0] addr;
    logic [PM_W-1:0] data;
  } fifo_entry_type;

  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic latch;
    logic [DATA_W-1:0] bus;
    logic tx_sync;
    logic rx_sync;
    logic rx_data;
    logic [STRAP_W-1:0] strap;
  } pin_in_type;

  typedef enum logic [1:0] {HOST_IDLE, HOST_READ, HOST_WRITE} host_state_type;
  typedef enum logic [1:0] {MEM_IDLE, MEM_WRITE, MEM_READ} mem_state_type;

endpackage : host_port_pkg

// file: hdl/sync_fifo.sv
// Flop-based FIFO with valid and ready on both sides
`timescale 1ns/1ns
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [WIDTH-1:0] store_next [DEPTH];
  logic [PTR_W:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic full;

  // Extra pointer bit tells full from empty
  assign full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
                (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
  assign in_ready = ~full;
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data = store_reg[rd_ptr_reg[PTR_W-1:0]];

  always_comb begin
    store_next = store_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (in_valid && !full) begin
      store_next[wr_ptr_reg[PTR_W-1:0]] = in_data;
      wr_ptr_next = wr_ptr_reg + (PTR_W+1)'(1);
    end
    if (out_valid && out_ready) begin
      rd_ptr_next = rd_ptr_reg + (PTR_W+1)'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        store_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      store_reg <= store_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

endmodule : sync_fifo

// file: sim/host_port_asserts.sv
// Checker for read handshake, straps and shared pin selection
`timescale 1ns/1ns
module host_port_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic host_select_n,
  input wire logic host_read_strobe_n,
  input wire logic [15:0] host_addr_data_out,
  input wire logic host_addr_data_oe,
  input wire logic host_acknowledge_n,
  input wire logic [15:0] host_port_overlay_ctrl,
  input wire logic [15:0] sys_ctrl,
  input wire logic [3:0] strap_bits,
  input wire logic ext_pins_host_fn,
  input wire logic plus_pins_dual_fn,
  input wire logic serial_tx_or_flag_out,
  input wire logic sport_tx_bit,
  input wire logic flag_out_bit,
  input wire logic tx_sync_or_irq_b_oe,
  input wire logic rx_sync_or_irq_a_oe,
  input wire logic irq_a_n,
  input wire logic irq_b_n,
  input wire logic flag_in_bit
);
  // ----------------------------------------
  // Edges since reset release, saturating
  // ----------------------------------------
  logic [2:0] edge_cnt_reg;
  logic [2:0] edge_cnt_next;
  always_comb begin
    edge_cnt_next = (edge_cnt_reg == 3'h7) ? edge_cnt_reg : edge_cnt_reg + 3'h1;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt_reg <= 3'h0;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_reset_values: assert property ($rose(rst_n) |->
    sys_ctrl == 16'h0400 && host_port_overlay_ctrl == 16'h0000) else $error("bad reset value");
  a_straps_held: assert property (edge_cnt_reg == 3'h7 |-> $stable(strap_bits))
    else $error("straps moved");
  a_strap_c_fn: assert property (edge_cnt_reg == 3'h7 |-> ext_pins_host_fn == strap_bits[2])
    else $error("host pin function wrong");
  a_plus_dual: assert property (edge_cnt_reg != 3'h0 |-> plus_pins_dual_fn)
    else $error("dual pins off");
  a_tx_pin_mux: assert property (1'b1 |=> serial_tx_or_flag_out ==
    ($past(sys_ctrl[10]) ? $past(sport_tx_bit) : $past(flag_out_bit))) else $error("tx mux");
  a_serial_idle: assert property (sys_ctrl[10] ##1 sys_ctrl[10] |->
    irq_a_n && irq_b_n && !flag_in_bit) else $error("irq active in serial mode");
  a_irq_no_drive: assert property (!sys_ctrl[10] ##1 !sys_ctrl[10] |->
    !tx_sync_or_irq_b_oe && !rx_sync_or_irq_a_oe) else $error("pin driven in irq mode");
  a_busy_on_read: assert property ($rose(host_addr_data_oe) |-> host_acknowledge_n)
    else $error("ack low at read start");
  a_read_start: assert property ($rose(host_addr_data_oe) |->
    !$past(host_select_n) && !$past(host_read_strobe_n)) else $error("drive without read");
  a_read_end: assert property (host_read_strobe_n [*8] |-> !host_addr_data_oe)
    else $error("bus driven after read");
  a_sro_hold: assert property (host_port_overlay_ctrl[14] && host_addr_data_oe &&
    $past(host_addr_data_oe) |-> $stable(host_addr_data_out)) else $error("word changed");
endmodule : host_port_asserts
bind internal_memory_host_port host_port_asserts u_host_port_asserts (.*);

// file: sim/host_model.sv
// Host processor model driving the parallel host port pins
`timescale 1ns/1ns
module host_model (
  input wire logic sys_clk,
  input wire logic host_acknowledge_n,
  input wire logic [15:0] bus_level,
  output logic sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic latch,
  output logic drive_oe,
  output logic [15:0] drive_val
);
  // ----------------------------------------
  // Pin sequences; holds cover the input filter
  // ----------------------------------------
  initial begin
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    latch = 1'b0;
    drive_oe = 1'b0;
    drive_val = 16'h0000;
  end
  task automatic wait_ready();
    @(posedge sys_clk);
    while (host_acknowledge_n !== 1'b0) @(posedge sys_clk);
  endtask : wait_ready
  task automatic put_addr(input logic [15:0] a);
    wait_ready();
    sel_n <= 1'b0;
    latch <= 1'b1;
    drive_oe <= 1'b1;
    drive_val <= a;
    repeat (6) @(posedge sys_clk);
    latch <= 1'b0;
    sel_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    drive_oe <= 1'b0;
  endtask : put_addr
  task automatic put_word(input logic [15:0] d);
    wait_ready();
    sel_n <= 1'b0;
    wr_n <= 1'b0;
    drive_oe <= 1'b1;
    drive_val <= d;
    @(posedge sys_clk);
    while (host_acknowledge_n !== 1'b1) @(posedge sys_clk);
    sel_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    drive_oe <= 1'b0;
  endtask : put_word
  task automatic get_word(output logic [15:0] d);
    wait_ready();
    sel_n <= 1'b0;
    rd_n <= 1'b0;
    @(posedge sys_clk);
    while (host_acknowledge_n !== 1'b1) @(posedge sys_clk);
    // Ack stays high on every read until the strobe ends, so the wait is bounded
    for (int i = 0; i < 12 && host_acknowledge_n !== 1'b0; i++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    d = bus_level;
    sel_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : get_word
endmodule : host_model

// file: sim/internal_memory_host_port_tb.sv
// Self-checking bench for the internal memory host port
`timescale 1ns/1ns
module internal_memory_host_port_tb;
  logic sys_clk, rst_n, host_select_n, host_read_strobe_n, host_write_strobe_n;
  logic host_addr_latch, host_addr_data_oe, host_acknowledge_n, mem_req, mem_we, mem_is_pm;
  logic core_ovl_we, core_sysctl_we, strap_pin_a, strap_pin_b, strap_pin_c, strap_pin_d;
  logic ext_pins_host_fn, plus_pins_dual_fn, serial_tx_or_flag_out, tx_sync_or_irq_b_in;
  logic tx_sync_or_irq_b_out, tx_sync_or_irq_b_oe, rx_sync_or_irq_a_in, rx_sync_or_irq_a_out;
  logic rx_sync_or_irq_a_oe, serial_rx_or_flag_in, sport_tx_bit, sport_tfs_out, sport_tfs_drive;
  logic sport_rfs_out, sport_rfs_drive, flag_out_bit, sport_rx_bit, sport_tfs_in, sport_rfs_in;
  logic irq_a_n, irq_b_n, flag_in_bit, drive_oe, tx_drv, rx_drv;
  logic mem_ack = 1'b0;
  logic [15:0] host_addr_data_in, host_addr_data_out, core_ovl_wdata, host_port_overlay_ctrl;
  logic [15:0] core_sysctl_wdata, sys_ctrl, drive_val, rd;
  logic [13:0] mem_addr;
  logic [23:0] mem_wdata, mem_rdata;
  logic [3:0] strap_bits;
  logic [23:0] dm_mem [16];
  logic [23:0] pm_mem [16];
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  internal_memory_host_port u_internal_memory_host_port (.*);
  host_model u_host (.sys_clk(sys_clk), .host_acknowledge_n(host_acknowledge_n),
    .bus_level(host_addr_data_in), .sel_n(host_select_n), .rd_n(host_read_strobe_n),
    .wr_n(host_write_strobe_n), .latch(host_addr_latch), .drive_oe(drive_oe),
    .drive_val(drive_val));
  // ----------------------------------------
  // Pins, memory and checking
  // ----------------------------------------
  // Undriven bus shows the inverse so a stale value cannot match
  assign host_addr_data_in = host_addr_data_oe ? host_addr_data_out :
    (drive_oe ? drive_val : ~drive_val);
  assign tx_sync_or_irq_b_in = tx_sync_or_irq_b_oe ? tx_sync_or_irq_b_out : tx_drv;
  assign rx_sync_or_irq_a_in = rx_sync_or_irq_a_oe ? rx_sync_or_irq_a_out : rx_drv;
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && !mem_ack && mem_we) begin
      if (mem_is_pm) begin
        pm_mem[mem_addr[3:0]] <= mem_wdata;
      end else begin
        dm_mem[mem_addr[3:0]] <= mem_wdata;
      end
    end
    mem_rdata <= mem_is_pm ? pm_mem[mem_addr[3:0]] : dm_mem[mem_addr[3:0]];
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    {rst_n, core_ovl_we, core_sysctl_we, sport_tfs_out, sport_rfs_out} = 5'h00;
    {sport_tfs_drive, sport_rfs_drive, flag_out_bit, tx_drv, rx_drv} = 5'h00;
    {strap_pin_d, strap_pin_c, strap_pin_b, strap_pin_a} = 4'h5;
    {core_ovl_wdata, core_sysctl_wdata} = 32'h0000_0000;
    serial_rx_or_flag_in = 1'b1;
    sport_tx_bit = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    check(sys_ctrl, 16'h0400);
    check(host_port_overlay_ctrl, 16'h0000);
    check({ext_pins_host_fn, plus_pins_dual_fn, strap_bits}, 6'h35);
    {strap_pin_c, strap_pin_a} <= 2'h0;
    repeat (8) @(posedge sys_clk);
    check(strap_bits, 4'h5);
    u_host.put_addr(16'h4010);
    u_host.put_word(16'h1111);
    u_host.put_word(16'h2222);
    u_host.put_addr(16'h4010);
    u_host.get_word(rd);
    check(rd, 16'h1111);
    u_host.get_word(rd);
    check(rd, 16'h2222);
    check(dm_mem[1], 24'h00_2222);
    core_ovl_wdata <= 16'h4000;
    core_ovl_we <= 1'b1;
    @(posedge sys_clk);
    core_ovl_we <= 1'b0;
    @(posedge sys_clk);
    check(host_port_overlay_ctrl, 16'h4000);
    u_host.put_addr(16'h4010);
    u_host.get_word(rd);
    check(rd, 16'h2222);
    u_host.get_word(rd);
    check(rd, 16'h1111);
    u_host.put_addr(16'h7fe7);
    u_host.put_word(16'h0000);
    repeat (8) @(posedge sys_clk);
    check(host_port_overlay_ctrl, 16'h0000);
    u_host.put_addr(16'h0020);
    u_host.put_word(16'habcd);
    u_host.put_word(16'h00ef);
    u_host.put_addr(16'h0020);
    u_host.get_word(rd);
    check(rd, 16'habcd);
    u_host.get_word(rd);
    check(rd, 16'h00ef);
    check(pm_mem[0], 24'hab_cdef);
    {sport_tfs_drive, sport_rfs_drive, sport_tfs_out, sport_rfs_out, rx_drv} <= 5'h1d;
    for (int m = 1; m >= 0; m--) begin
      core_sysctl_wdata <= (m == 1) ? 16'h0400 : 16'h0000;
      core_sysctl_we <= 1'b1;
      sport_tx_bit <= m[0];
      flag_out_bit <= !m[0];
      serial_rx_or_flag_in <= !m[0];
      @(posedge sys_clk);
      core_sysctl_we <= 1'b0;
      repeat (8) @(posedge sys_clk);
      check(serial_tx_or_flag_out, 1'b1);
      check({irq_a_n, irq_b_n, flag_in_bit, sport_rx_bit, sport_tfs_in, sport_rfs_in},
        (m == 1) ? 6'h32 : 6'h28);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(sys_ctrl, 16'h0400);
    complete_run();
  end
endmodule : internal_memory_host_port_tb
